// ==== hw/acis_pkg.sv ====
// Package: register map, field layout and types of the converter clock and input select
package acis_pkg;

    // Word register byte addresses (offsets chosen, one aligned word each)
    localparam logic [3:0] ACIS_TIMING_ADDR = 4'h0;
    localparam logic [3:0] ACIS_TRIO_ADDR   = 4'h4;
    localparam logic [3:0] ACIS_FIRST_ADDR  = 4'h8;
    localparam logic [3:0] ACIS_SCAN_ADDR   = 4'hc;
    localparam logic [4:0] ACIS_CTRL_ADDR   = 5'h10;

    // Timing register fields, register write masks and reset value
    localparam int ACIS_SRC_BIT       = 15;
    localparam int ACIS_SAMPLE_LSB    = 8;
    localparam int ACIS_DIV_LSB       = 0;
    localparam logic [15:0] ACIS_TIMING_MASK = 16'h9fff;
    localparam logic [15:0] ACIS_TRIO_MASK   = 16'h0707;
    localparam logic [15:0] ACIS_FIRST_MASK  = 16'h9f9f;
    localparam logic [15:0] ACIS_SCAN_MASK   = 16'h01ff;
    localparam logic [15:0] ACIS_CTRL_MASK   = 16'h0f07;
    localparam logic [15:0] ACIS_RESET_VAL   = 16'h0000;

    // Divider limit and trigger code for auto-convert
    localparam logic [7:0] ACIS_DIV_MAX  = 8'h3f;
    localparam logic [2:0] ACIS_TRIG_AUTO = 3'h7;
    localparam int         ACIS_NUM_IN    = 9;

    // Mux select codes to the analog side
    localparam logic [3:0] ACIS_SEL_LOW_REF = 4'hf;
    localparam logic [3:0] ACIS_SEL_NREF  = 4'he;

    typedef enum logic [2:0] {
        ACIS_IDLE = 3'b001,
        ACIS_SAMP = 3'b010,
        ACIS_CONV = 3'b100
    } acis_state_e;

    typedef struct packed {
        logic [3:0] first_pos;
        logic [3:0] first_neg;
        logic [3:0] trio_pos_base;
        logic [3:0] trio_neg_base;
    } acis_mux_s;

endpackage : acis_pkg

// ==== hw/acis_div.sv ====
// Conversion clock period generator: one-cycle enable per period
`timescale 1ns/1ps
module acis_div (
    input  wire logic       clk_i,        // System clock
    input  wire logic       rst_i,        // Synchronous reset
    input  wire logic       rc_sel_i,     // Internal RC source selected
    input  wire logic       rc_tick_i,    // RC clock tick, already synchronised
    input  wire logic [7:0] div_i,        // Divider field
    output logic            tick_o        // One conversion clock period elapsed
);
    import acis_pkg::*;

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        cnt_d  = cnt_q;
        tick_d = 1'b0;
        if (rc_sel_i) begin
            cnt_d  = 8'h00;
            tick_d = rc_tick_i;
        end else if (cnt_q >= div_i) begin
            cnt_d  = 8'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_o = tick_q;

    a_div_period: assert property (@(posedge clk_i) disable iff (rst_i)
        (!rc_sel_i && cnt_q == 8'h00 && $past(cnt_q) != 8'h00 && $stable(div_i)
            && !$past(rc_sel_i)) |-> tick_q)
        else $error("divider tick missing after wrap");
    a_div_rc: assert property (@(posedge clk_i) disable iff (rst_i)
        rc_sel_i |-> ##1 (tick_q == $past(rc_tick_i)))
        else $error("rc tick not passed through");
endmodule : acis_div

// ==== hw/acis_top.sv ====
// Converter clock source, sample timer and analog input select logic
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
module acis_top #(
    parameter int NUM_PINS = 9                        // Analog inputs bonded out
) (
    input  wire logic              clk_i,             // 200 MHz system clock
    input  wire logic              rst_i,             // Synchronous reset, high
    input  wire logic              wb_cyc_i,          // Wishbone cycle
    input  wire logic              wb_stb_i,          // Wishbone strobe
    input  wire logic              wb_we_i,           // Wishbone write enable
    input  wire logic [4:0]        wb_adr_i,          // Wishbone byte address
    input  wire logic [3:0]        wb_sel_i,          // Wishbone byte selects
    input  wire logic [31:0]       wb_dat_i,          // Wishbone write data
    output logic      [31:0]       wb_dat_o,          // Wishbone read data
    output logic                   wb_ack_o,          // Wishbone acknowledge
    input  wire logic              rc_clk_i,          // Internal RC oscillator pin
    input  wire logic              sample_start_i,    // Sampling begins, pulse
    input  wire logic              conv_done_i,       // Core finished conversion, pulse
    output logic                   conv_start_o,      // End sampling, start conversion
    output logic                   sampling_o,        // Sample-and-hold tracking
    output logic                   tad_tick_o,        // Conversion clock period pulse
    output acis_pkg::acis_mux_s    mux_o,             // Mux selects to analog side
    output logic                   sample_b_o         // Current sample uses B selects
);
    import acis_pkg::*;

    initial begin
        if (NUM_PINS < 6 || NUM_PINS > ACIS_NUM_IN) begin
            $error("NUM_PINS must be 6 to 9");
        end
    end

    // Registers
    logic [15:0] timing_q, timing_d;
    logic [15:0] trio_q, trio_d;
    logic [15:0] first_q, first_d;
    logic [15:0] scan_q, scan_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [31:0] rdat_q, rdat_d;
    logic        ack_q, ack_d;

    wire logic       src_rc     = timing_q[ACIS_SRC_BIT];
    wire logic [4:0] auto_sample_periods = timing_q[ACIS_SAMPLE_LSB +: 5];
    wire logic [7:0] divider    = timing_q[ACIS_DIV_LSB +: 8];
    wire logic [2:0] trig_src   = ctrl_q[2:0];
    wire logic       res12      = ctrl_q[8];
    wire logic       scan_en    = ctrl_q[9];
    wire logic       alt_mode   = ctrl_q[10];

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (sel[0]) v[7:0]  = wd[7:0];
        if (sel[1]) v[15:8] = wd[15:8];
        merge = v & mask;
    endfunction : merge

    wire logic req = wb_cyc_i && wb_stb_i && !ack_q;

    always_comb begin
        timing_d = timing_q;
        trio_d   = trio_q;
        first_d  = first_q;
        scan_d   = scan_q;
        ctrl_d   = ctrl_q;
        rdat_d   = rdat_q;
        ack_d    = req;
        if (req) begin
            rdat_d = 32'h0000_0000;
            if (wb_adr_i == {1'b0, ACIS_TIMING_ADDR}) begin
                rdat_d[15:0] = timing_q;
                if (wb_we_i) timing_d = merge(timing_q, wb_dat_i, wb_sel_i, ACIS_TIMING_MASK);
            end else if (wb_adr_i == {1'b0, ACIS_TRIO_ADDR}) begin
                rdat_d[15:0] = trio_q;
                if (wb_we_i) trio_d = merge(trio_q, wb_dat_i, wb_sel_i, ACIS_TRIO_MASK);
            end else if (wb_adr_i == {1'b0, ACIS_FIRST_ADDR}) begin
                rdat_d[15:0] = first_q;
                if (wb_we_i) first_d = merge(first_q, wb_dat_i, wb_sel_i, ACIS_FIRST_MASK);
            end else if (wb_adr_i == {1'b0, ACIS_SCAN_ADDR}) begin
                rdat_d[15:0] = scan_q;
                if (wb_we_i) scan_d = merge(scan_q, wb_dat_i, wb_sel_i, ACIS_SCAN_MASK);
            end else if (wb_adr_i == ACIS_CTRL_ADDR) begin
                rdat_d[15:0] = ctrl_q;
                rdat_d[16]   = sampling_o;
                rdat_d[17]   = sample_b_o;
                if (wb_we_i) ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i, ACIS_CTRL_MASK);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timing_q <= ACIS_RESET_VAL;
            trio_q   <= ACIS_RESET_VAL;
            first_q  <= ACIS_RESET_VAL;
            scan_q   <= ACIS_RESET_VAL;
            ctrl_q   <= ACIS_RESET_VAL;
            rdat_q   <= 32'h0000_0000;
            ack_q    <= 1'b0;
        end else begin
            timing_q <= timing_d;
            trio_q   <= trio_d;
            first_q  <= first_d;
            scan_q   <= scan_d;
            ctrl_q   <= ctrl_d;
            rdat_q   <= rdat_d;
            ack_q    <= ack_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;

    // RC pin synchroniser and edge detect on the second stage
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
        end else begin
            rc_s1_q <= rc_clk_i;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
        end
    end

    logic tick;
    acis_div u_div (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .rc_sel_i  (src_rc),
        .rc_tick_i (rc_s2_q && !rc_s3_q),
        .div_i     (divider),
        .tick_o    (tick)
    );

    // Sample timer state machine
    acis_state_e st_q, st_d;
    logic [4:0]  tcnt_q, tcnt_d;
    logic        start_q, start_d;
    logic        alt_q, alt_d;
    logic [3:0]  scan_ptr_q, scan_ptr_d;

    function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [8:0] m);
        logic [3:0] r;
        logic       found;
        r = cur;
        found = 1'b0;
        for (int k = 1; k <= ACIS_NUM_IN; k++) begin
            if (!found && m[(32'(cur) + k) % ACIS_NUM_IN]) begin
                r = 4'((32'(cur) + k) % ACIS_NUM_IN);
                found = 1'b1;
            end
        end
        next_scan = r;
    endfunction : next_scan

    // Skip a pointer that sits on an unselected input
    wire logic [3:0] scan_cur = scan_q[scan_ptr_q] ? scan_ptr_q
                                                   : next_scan(scan_ptr_q, scan_q[8:0]);

    always_comb begin
        st_d       = st_q;
        tcnt_d     = tcnt_q;
        start_d    = 1'b0;
        alt_d      = alt_q;
        scan_ptr_d = scan_ptr_q;
        case (st_q)
            ACIS_IDLE: begin
                if (sample_start_i) begin
                    st_d   = ACIS_SAMP;
                    tcnt_d = 5'h00;
                end
            end
            ACIS_SAMP: begin
                if (trig_src == ACIS_TRIG_AUTO) begin
                    if (tcnt_q >= auto_sample_periods) begin
                        st_d    = ACIS_CONV;
                        start_d = 1'b1;
                    end else if (tick) begin
                        tcnt_d = tcnt_q + 5'h01;
                    end
                end else if (sample_start_i) begin
                    st_d    = ACIS_CONV;
                    start_d = 1'b1;
                end
            end
            ACIS_CONV: begin
                if (conv_done_i) begin
                    st_d  = ACIS_IDLE;
                    alt_d = alt_mode ? !alt_q : 1'b0;
                    if (scan_en && !alt_q) begin
                        scan_ptr_d = next_scan(scan_cur, scan_q[8:0]);
                    end
                end
            end
            default: st_d = ACIS_IDLE;
        endcase
        if (!alt_mode) alt_d = 1'b0;
    end

    // Mux selects for the current sample
    acis_mux_s mux_d, mux_q;
    logic [3:0] pos_sel;
    logic [4:0] pos_code;
    always_comb begin
        pos_code = alt_q ? first_q[12:8] : first_q[4:0];
        if (scan_en && !alt_q) pos_code = {1'b0, scan_cur};
        pos_sel = pos_code[3:0];
        if (32'(pos_code) >= NUM_PINS) pos_sel = ACIS_SEL_LOW_REF;
        mux_d.first_pos = pos_sel;
        mux_d.first_neg = (alt_q ? first_q[15] : first_q[7]) ? 4'h1 : ACIS_SEL_NREF;
        mux_d.trio_pos_base = (alt_q ? trio_q[8] : trio_q[0]) ? 4'h3 : 4'h0;
        mux_d.trio_neg_base = ACIS_SEL_NREF;
        if ((alt_q ? trio_q[10:9] : trio_q[2:1]) == 2'b10 && NUM_PINS == ACIS_NUM_IN)
            mux_d.trio_neg_base = 4'h6;
        if (res12) begin
            mux_d.trio_pos_base = ACIS_SEL_LOW_REF;
            mux_d.trio_neg_base = ACIS_SEL_LOW_REF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q       <= ACIS_IDLE;
            tcnt_q     <= 5'h00;
            start_q    <= 1'b0;
            alt_q      <= 1'b0;
            scan_ptr_q <= 4'h0;
            mux_q      <= '0;
        end else begin
            st_q       <= st_d;
            tcnt_q     <= tcnt_d;
            start_q    <= start_d;
            alt_q      <= alt_d;
            scan_ptr_q <= scan_ptr_d;
            mux_q      <= mux_d;
        end
    end

    logic samp_q, tick_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            samp_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            samp_q <= (st_d == ACIS_SAMP);
            tick_q <= tick;
        end
    end

    assign conv_start_o = start_q;
    assign sampling_o   = samp_q;
    assign tad_tick_o   = tick_q;
    assign mux_o        = mux_q;
    assign sample_b_o   = alt_q;

    a_auto_end: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ACIS_SAMP && trig_src == ACIS_TRIG_AUTO && tcnt_q >= auto_sample_periods)
            |-> ##1 (start_q && st_q == ACIS_CONV))
        else $error("auto sample did not end");
    a_no_auto: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ACIS_SAMP && trig_src != ACIS_TRIG_AUTO && !sample_start_i)
            |-> ##1 !start_q)
        else $error("conversion started without trigger");
    a_first_neg: assert property (@(posedge clk_i) disable iff (rst_i)
        (!alt_q && first_q[7] && $stable(first_q)) |-> ##1 (mux_q.first_neg == 4'h1))
        else $error("first negative select wrong");
    a_trio_pos: assert property (@(posedge clk_i) disable iff (rst_i)
        (!res12 && !alt_q && trio_q[0]) |-> ##1 (mux_q.trio_pos_base == 4'h3 || $changed(alt_q)
            || $changed(trio_q) || $changed(res12)))
        else $error("trio positive select wrong");
    a_unused_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (timing_q & ~ACIS_TIMING_MASK) == 16'h0000 && (scan_q & ~ACIS_SCAN_MASK) == 16'h0000)
        else $error("reserved bits set");
    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !ack_q) |-> ##1 ack_q ##1 !ack_q)
        else $error("ack timing wrong");
    a_alt_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !alt_mode |-> ##1 !alt_q)
        else $error("sample B used with alternate off");
    a_tick_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_q == ACIS_SAMP && tick && tcnt_q < auto_sample_periods && trig_src == ACIS_TRIG_AUTO)
            |-> ##1 (tcnt_q == $past(tcnt_q) + 5'h01))
        else $error("sample count not advanced");
endmodule : acis_top

// ==== bench/acis_core_model.sv ====
// Converter core and RC oscillator stand-in on the far side of the select block
`timescale 1ns/1ps
module acis_core_model #(
    parameter int CONV_CYC = 12                 // Base conversion length in cycles
) (
    input  wire logic       clk_i,              // System clock
    input  wire logic       rst_i,              // Synchronous reset
    input  wire logic       conv_start_i,       // Start conversion pulse
    input  wire logic       start_req_i,        // Bench asks for a sampling start
    input  wire logic [7:0] delay_i,            // Extra cycles for slow answers
    output logic            sample_start_o,     // Sampling begins, pulse
    output logic            conv_done_o,        // Conversion finished, pulse
    output logic            rc_clk_o            // Free-running RC oscillator
);
    int cnt;

    // Oscillator runs free, unrelated in phase to the system clock
    initial begin
        rc_clk_o       = 1'b0;
        forever #17.3 rc_clk_o = ~rc_clk_o;
    end

    always @(posedge clk_i) begin
        sample_start_o <= start_req_i;
        conv_done_o    <= 1'b0;
        if (rst_i) begin
            cnt <= 0;
        end else if (conv_start_i) begin
            cnt <= CONV_CYC + int'(delay_i);
        end else if (cnt > 0) begin
            cnt         <= cnt - 1;
            conv_done_o <= (cnt == 1);
        end
    end
endmodule : acis_core_model

// ==== bench/acis_top_tb.sv ====
// Self-checking bench for the converter clock and input select block
`timescale 1ns/1ps
module acis_top_tb;
    import acis_pkg::*;
    localparam int NP = 9;
    logic clk, rst, cyc, stb, we, rc, ss, cd, cs, smp, tick, sb, start_req, ack;
    logic [4:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [7:0] dly;
    acis_mux_s mux;
    logic [15:0] regs [5];
    logic [31:0] seed;
    logic [3:0] fp_seen;
    int fail_count, total_checks;
    localparam logic [4:0] ADR [5] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10};
    localparam logic [15:0] MSK [5] = '{ACIS_TIMING_MASK, ACIS_TRIO_MASK,
        ACIS_FIRST_MASK, ACIS_SCAN_MASK, ACIS_CTRL_MASK};

    acis_top #(.NUM_PINS(NP)) u_acis_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .rc_clk_i(rc), .sample_start_i(ss),
        .conv_done_i(cd), .conv_start_o(cs), .sampling_o(smp), .tad_tick_o(tick),
        .mux_o(mux), .sample_b_o(sb));
    acis_core_model u_acis_core_model (.clk_i(clk), .rst_i(rst), .conv_start_i(cs),
        .start_req_i(start_req), .delay_i(dly), .sample_start_o(ss), .conv_done_o(cd),
        .rc_clk_o(rc));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic guard(input int n, input int lim);
        if (n >= lim) begin
            $display("Error wait expected event seen timeout");
            fail_count++;
            summarize();
        end
    endtask : guard

    // Classic single cycle: hold until ack sampled high, then release
    task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {16'h0, d};
        n = 0;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        guard(n, 20);
    endtask : wb

    task automatic wr(input int i, input logic [15:0] d);
        wb(1'b1, ADR[i], d, 4'h3);
        regs[i] = d & MSK[i];
    endtask : wr

    task automatic rdchk(input int i);
        wb(1'b0, ADR[i], 16'h0, 4'h3);
        chk("reg_read", {16'h0, regs[i]}, q);
    endtask : rdchk

    function automatic acis_mux_s exp_mux(input logic b);
        acis_mux_s m;
        logic [7:0] f, t;
        f = b ? regs[2][15:8] : regs[2][7:0];
        t = b ? regs[1][15:8] : regs[1][7:0];
        m.first_pos = (f[4:0] < NP) ? f[3:0] : ACIS_SEL_LOW_REF;
        m.first_neg = f[7] ? 4'h1 : ACIS_SEL_NREF;
        m.trio_pos_base = regs[4][8] ? ACIS_SEL_LOW_REF : (t[0] ? 4'h3 : 4'h0);
        m.trio_neg_base = regs[4][8] ? ACIS_SEL_LOW_REF : (t[2:1] == 2'h2 ? 4'h6 : ACIS_SEL_NREF);
        return m;
    endfunction : exp_mux

    task automatic pulse_start();
        @(posedge clk) start_req <= 1'b1;
        @(posedge clk) start_req <= 1'b0;
    endtask : pulse_start

    // One sample and conversion ended by a second start, outside auto mode
    task automatic run_conv(input int hold);
        int n, early;
        pulse_start();
        n = 0;
        while (smp !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        guard(n, 50);
        fp_seen = mux.first_pos;
        early = 0;
        repeat (hold) begin @(posedge clk); if (cs === 1'b1) early++; end
        chk("early_conv", 0, early);
        pulse_start();
        n = 0;
        while (cs !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        guard(n, 50);
        n = 0;
        while (cd !== 1'b1 && n < 400) begin @(posedge clk); n++; end
        guard(n, 400);
        repeat (3) @(posedge clk);
    endtask : run_conv

    task automatic period(input logic [7:0] d);
        int n;
        wr(0, {8'h00, d});
        n = 0;
        repeat (2) begin
            @(posedge clk);
            while (tick !== 1'b1 && n < 600) begin @(posedge clk); n++; end
        end
        guard(n, 600);
        n = 0;
        do begin @(posedge clk); n++; end while (tick !== 1'b1 && n < 600);
        chk("tad_period", int'(d) + 1, n);
    endtask : period

    task automatic auto_run(input logic [4:0] s, input logic [7:0] d);
        int n, t;
        wr(4, 16'h0007);
        wr(0, {3'h0, s, d});
        pulse_start();
        n = 0; t = 0;
        while (smp !== 1'b1 && n < 50) begin @(posedge clk); n++; end
        guard(n, 50);
        n = 0;
        while (cs !== 1'b1 && n < 3000) begin @(posedge clk); n++; if (tick === 1'b1) t++; end
        guard(n, 3000);
        chk("auto_ticks", 1, (t >= int'(s) - 1) && (t <= int'(s) + 1));
        n = 0;
        while (cd !== 1'b1 && n < 400) begin @(posedge clk); n++; end
        guard(n, 400);
        repeat (3) @(posedge clk);
    endtask : auto_run

    initial begin
        int n, nxt;
        logic [31:0] r;
        seed = 32'd27340;
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h0; sel = 4'h0;
        wdat = 32'h0; start_req = 1'b0; dly = 8'h0; fail_count = 0; total_checks = 0;
        foreach (regs[i]) regs[i] = ACIS_RESET_VAL;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rdchk(i);
        for (int i = 0; i < 5; i++) begin wr(i, 16'hffff); rdchk(i); end
        wb(1'b1, 5'h14, 16'hffff, 4'h3);
        wb(1'b0, 5'h14, 16'h0, 4'h3);
        chk("unmapped", 0, q);
        for (int k = 0; k < 12; k++) begin
            r = rnd();
            n = int'(r[2:0]) % 5;
            wb(1'b1, ADR[n], r[31:16], {2'h0, r[4:3]});
            if (r[3]) regs[n][7:0] = r[23:16] & MSK[n][7:0];
            if (r[4]) regs[n][15:8] = r[31:24] & MSK[n][15:8];
            rdchk(n);
        end
        $display("test registers done");
        wr(4, 16'h0000);
        period(8'h00);
        period(8'h01);
        period(8'h05);
        period(8'h3f);
        wr(0, 16'h803f);
        n = 0;
        repeat (350) begin @(posedge clk); if (tick === 1'b1) n++; end
        chk("rc_ticks", 1, n >= 48 && n <= 53);
        $display("test clock done");
        auto_run(5'd5, 8'd3);
        auto_run(5'd31, 8'd0);
        auto_run(5'd0, 8'd2);
        for (int c = 0; c < 7; c++) begin
            wr(4, c[15:0]);
            wr(0, 16'h1f00);
            run_conv(40);
        end
        $display("test trigger done");
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            wr(4, {7'h0, r[16], 8'h0});
            wr(2, {r[15], 2'h0, r[12:8], r[7], 2'h0, r[4:0]});
            wr(1, {5'h0, r[20] & ~r[19], r[19], r[21], 5'h0, r[18] & ~r[17], r[17], r[22]});
            repeat (3) @(posedge clk);
            chk("mux_a", {16'h0, exp_mux(1'b0)}, {16'h0, mux});
        end
        wr(4, 16'h0400);
        wr(2, 16'h0583);
        wr(1, 16'h0502);
        for (int k = 0; k < 2; k++) begin
            r = rnd();
            dly <= r[7:0];
            run_conv(2);
            chk("sample_b", {31'h0, ~k[0]}, {31'h0, sb});
            chk("mux_alt", {16'h0, exp_mux(~k[0])}, {16'h0, mux});
        end
        $display("test alternate done");
        dly <= 8'h0;
        wr(3, 16'h0122);
        wr(4, 16'h0200);
        run_conv(2);
        chk("scan_first", 1, regs[3][fp_seen]);
        for (int k = 0; k < 4; k++) begin
            nxt = (int'(fp_seen) + 1) % 9;
            while (!regs[3][nxt]) nxt = (nxt + 1) % 9;
            run_conv(2);
            chk("scan_next", nxt, {28'h0, fp_seen});
        end
        $display("test scan done");
        summarize();
    end

    initial begin
        repeat (90000) @(posedge clk);
        $display("Error run expected finish seen timeout");
        fail_count++;
        summarize();
    end
endmodule : acis_top_tb
